// [hw/output_clock_control_regs.sv]
// output clock control register bank: filter corner, t1 phase offset, clock disables
// Notes on behaviour
// - low filter range: 1.5 Hz or 0.1 Hz
// - high filter range: 12 Hz or 6 Hz
// - phase offset is unsigned zero to seven
// - 16.384 MHz output tristated when disabled
// - 8.192 MHz output tristated when disabled
// - 4.096 MHz output tristated when disabled
// - 2.048 MHz output tristated when disabled
// - 1.544 MHz output tristated when disabled
`timescale 1ns/1ps
module output_clock_control_regs (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          srst,
  // register port
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [7:0]                    reg_rdata,
  // generated clocks from the synthesiser
  input  wire logic                          clk16m_in,
  input  wire logic                          clk8m_in,
  input  wire logic                          clk4m_in,
  input  wire logic                          clk2m_in,
  input  wire logic                          t1_clock_in,
  // output pads, enable low while driving
  output wire logic [4:0]                    clk_pad_out,
  output wire logic [4:0]                    clk_pad_oe_n,
  // controls to the loop filter and synthesiser
  output logic                               filter_sel_high,
  output logic                               filter_sel_low,
  output clk_ctrl_pkg::filter_corner_t       filter_corner,
  output logic      [15:0]                   filter_corner_mhz,
  output logic      [2:0]                    t1_clock_phase_offset,
  output logic      [31:0]                   t1_clock_phase_ps
);
  typedef struct packed {
    logic [7:0]                   ctrl_filter;
    logic [7:0]                   clock_off_a;
    logic [7:0]                   rdata;
    clk_ctrl_pkg::filter_corner_t corner;
    logic [15:0]                  corner_mhz;
    logic [31:0]                  phase_ps;
  } state_t;

  state_t st;
  state_t next_st;
  logic [4:0] off_vec;
  logic       hit_filter;
  logic       hit_off;

  // one address decode shared by reads and writes
  always_comb
  begin
    hit_filter = 1'b0;
    hit_off    = 1'b0;
    // reserved offsets leave both hits low, so they read zero
    if (reg_addr == clk_ctrl_pkg::ctrl_filter_addr)
    begin
      hit_filter = 1'b1;
    end
    else if (reg_addr == clk_ctrl_pkg::clock_off_a_addr)
    begin
      hit_off = 1'b1;
    end
  end

  // next state built in one place; reset last so it overrides strobes
  always_comb
  begin
    next_st = st;
    // read data stand one cycle, then drop to zero
    next_st.rdata = 8'h00;
    if (reg_wr)
    begin
      // masking keeps reserved bits at zero whatever is written
      if (hit_filter)
      begin
        next_st.ctrl_filter = reg_wdata & clk_ctrl_pkg::ctrl_filter_mask;
      end
      else if (hit_off)
      begin
        next_st.clock_off_a = reg_wdata & clk_ctrl_pkg::clock_off_a_mask;
      end
    end
    if (reg_rd)
    begin
      // unmapped addresses read zero
      if (hit_filter)
      begin
        next_st.rdata = st.ctrl_filter;
      end
      else if (hit_off)
      begin
        next_st.rdata = st.clock_off_a;
      end
    end
    case ({next_st.ctrl_filter[clk_ctrl_pkg::filter_high_bit],
           next_st.ctrl_filter[clk_ctrl_pkg::filter_low_bit]})
      2'b00:
      begin
        next_st.corner = clk_ctrl_pkg::corner_1p5;
      end
      2'b01:
      begin
        next_st.corner = clk_ctrl_pkg::corner_0p1;
      end
      2'b10:
      begin
        next_st.corner = clk_ctrl_pkg::corner_12;
      end
      default:
      begin
        next_st.corner = clk_ctrl_pkg::corner_6;
      end
    endcase

    // millihertz figure follows the chosen corner, so the two stay in step
    case (next_st.corner)
      clk_ctrl_pkg::corner_1p5:
      begin
        next_st.corner_mhz = clk_ctrl_pkg::corner_1p5_mhz;
      end
      clk_ctrl_pkg::corner_0p1:
      begin
        next_st.corner_mhz = clk_ctrl_pkg::corner_0p1_mhz;
      end
      clk_ctrl_pkg::corner_12:
      begin
        next_st.corner_mhz = clk_ctrl_pkg::corner_12_mhz;
      end
      default:
      begin
        next_st.corner_mhz = clk_ctrl_pkg::corner_6_mhz;
      end
    endcase
    // absolute position: a smaller value moves the clock back; no glitch guard here
    next_st.phase_ps = 32'(clk_ctrl_pkg::phase_step_ps)
      * 32'(next_st.ctrl_filter[clk_ctrl_pkg::phase_lsb +: clk_ctrl_pkg::phase_w]);
    if (srst)
    begin
      next_st.ctrl_filter = clk_ctrl_pkg::ctrl_filter_rst;
      next_st.clock_off_a = clk_ctrl_pkg::clock_off_a_rst;
      next_st.rdata       = 8'h00;
      next_st.corner      = clk_ctrl_pkg::corner_1p5;
      next_st.corner_mhz  = clk_ctrl_pkg::corner_1p5_mhz;
      next_st.phase_ps    = 32'h0000_0000;
    end
  end

  // srst is folded into next_st, so the flop stays a plain register
  always_ff @(posedge clk_sys)
  begin
    st <= next_st;
  end

  // register fields straight to the loop filter and synthesiser
  assign reg_rdata             = st.rdata;
  assign filter_sel_high       = st.ctrl_filter[clk_ctrl_pkg::filter_high_bit];
  assign filter_sel_low        = st.ctrl_filter[clk_ctrl_pkg::filter_low_bit];
  assign filter_corner         = st.corner;
  assign filter_corner_mhz     = st.corner_mhz;
  assign t1_clock_phase_offset = st.ctrl_filter[clk_ctrl_pkg::phase_lsb +: clk_ctrl_pkg::phase_w];
  assign t1_clock_phase_ps     = st.phase_ps;

  // pad order: 4=16M 3=8M 2=4M 1=2M 0=1.544M
  assign off_vec = {st.clock_off_a[clk_ctrl_pkg::clk16m_off_bit],
                    st.clock_off_a[clk_ctrl_pkg::clk8m_off_bit],
                    st.clock_off_a[clk_ctrl_pkg::clk4m_off_bit],
                    st.clock_off_a[clk_ctrl_pkg::clk2m_off_bit],
                    st.clock_off_a[clk_ctrl_pkg::t1_clock_off_bit]};

  // 16.384 MHz pad
  clk_out_gate u_gate_16m (
    .off      (off_vec[4]),
    .clk_in   (clk16m_in),
    .pad_out  (clk_pad_out[4]),
    .pad_oe_n (clk_pad_oe_n[4])
  );

  // 8.192 MHz pad
  clk_out_gate u_gate_8m (
    .off      (off_vec[3]),
    .clk_in   (clk8m_in),
    .pad_out  (clk_pad_out[3]),
    .pad_oe_n (clk_pad_oe_n[3])
  );

  // 4.096 MHz pad
  clk_out_gate u_gate_4m (
    .off      (off_vec[2]),
    .clk_in   (clk4m_in),
    .pad_out  (clk_pad_out[2]),
    .pad_oe_n (clk_pad_oe_n[2])
  );

  // 2.048 MHz pad
  clk_out_gate u_gate_2m (
    .off      (off_vec[1]),
    .clk_in   (clk2m_in),
    .pad_out  (clk_pad_out[1]),
    .pad_oe_n (clk_pad_oe_n[1])
  );

  // 1.544 MHz pad
  clk_out_gate u_gate_t1 (
    .off      (off_vec[0]),
    .clk_in   (t1_clock_in),
    .pad_out  (clk_pad_out[0]),
    .pad_oe_n (clk_pad_oe_n[0])
  );
endmodule

// [hw/clk_ctrl_pkg.sv]
// package of register map constants for the output clock control bank
package clk_ctrl_pkg;
  // register offsets (byte addresses on the plain register port)
  localparam logic [7:0] ctrl_filter_addr  = 8'h12;
  localparam logic [7:0] clock_off_a_addr  = 8'h13;
  // filter and phase register field positions
  localparam int unsigned phase_lsb        = 0;
  localparam int unsigned phase_w          = 3;
  localparam int unsigned filter_high_bit  = 4;
  localparam int unsigned filter_low_bit   = 5;
  // clock disable register field positions
  localparam int unsigned clk16m_off_bit   = 5;
  localparam int unsigned clk8m_off_bit    = 4;
  localparam int unsigned clk4m_off_bit    = 3;
  localparam int unsigned clk2m_off_bit    = 2;
  localparam int unsigned t1_clock_off_bit = 1;
  // writable masks; every other bit is reserved
  localparam logic [7:0] ctrl_filter_mask  = 8'h37;
  localparam logic [7:0] clock_off_a_mask  = 8'h3E;
  // reset values
  localparam logic [7:0] ctrl_filter_rst   = 8'h00;
  localparam logic [7:0] clock_off_a_rst   = 8'h00;
  // phase step of the 1.544 MHz output, in picoseconds
  localparam int unsigned phase_step_ps    = 80960;
  // corner frequencies in millihertz
  localparam logic [15:0] corner_1p5_mhz   = 16'h05DC;
  localparam logic [15:0] corner_0p1_mhz   = 16'h0064;
  localparam logic [15:0] corner_12_mhz    = 16'h2EE0;
  localparam logic [15:0] corner_6_mhz     = 16'h1770;
  typedef enum logic [1:0] {
    corner_1p5,
    corner_0p1,
    corner_12,
    corner_6
  } filter_corner_t;
endpackage

// [hw/clk_out_gate.sv]
// one tristate control for a generated clock output
`timescale 1ns/1ps
module clk_out_gate (
  // control
  input  wire logic off,
  // clock from the synthesiser
  input  wire logic clk_in,
  // pad side
  output wire logic pad_out,
  output wire logic pad_oe_n
);
  assign pad_out  = clk_in & ~off;
  assign pad_oe_n = off;
endmodule

// [verification/occr_assertions.sv]
// assertion checker for the output clock control bank
`timescale 1ns/1ps
module occr_assert (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        srst,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // controls
  input wire logic [4:0]  clk_pad_out,
  input wire logic [4:0]  clk_pad_oe_n,
  input wire logic        filter_sel_high,
  input wire logic        filter_sel_low,
  input wire logic [15:0] filter_corner_mhz,
  input wire logic [2:0]  t1_clock_phase_offset,
  input wire logic [31:0] t1_clock_phase_ps
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence wr_off; reg_wr && reg_addr == 8'h13; endsequence
  sequence wr_flt; reg_wr && reg_addr == 8'h12; endsequence
  sequence rd_off; reg_rd && reg_addr == 8'h13; endsequence
  AST_OE_WR: assert property (wr_off |=> clk_pad_oe_n == $past(reg_wdata[5:1]))
    else $error("disable bits not taken");
  AST_PH_WR: assert property (wr_flt |=> t1_clock_phase_offset == $past(reg_wdata[2:0]))
    else $error("phase offset not taken");
  AST_OE_HOLD: assert property (!reg_wr |=> $stable(clk_pad_oe_n))
    else $error("disable bits moved without write");
  AST_PAD: assert property ((clk_pad_out & clk_pad_oe_n) == 5'h00)
    else $error("pad driven while disabled");
  AST_LO: assert property (!filter_sel_high |->
    filter_corner_mhz == (filter_sel_low ? 16'h0064 : 16'h05DC))
    else $error("low range corner wrong");
  AST_HI: assert property (filter_sel_high |->
    filter_corner_mhz == (filter_sel_low ? 16'h1770 : 16'h2EE0))
    else $error("high range corner wrong");
  AST_PS: assert property (t1_clock_phase_ps == t1_clock_phase_offset * 32'h00013C40)
    else $error("phase step wrong");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read");
  AST_RD_OFF: assert property (rd_off |=> reg_rdata == {2'b00, clk_pad_oe_n, 1'b0})
    else $error("disable register readback wrong");
endmodule
bind output_clock_control_regs occr_assert i_chk (.*);

// [verification/output_clock_control_regs_bench.sv]
// self-checking bench for the output clock control bank
`timescale 1ns/1ps
module output_clock_control_regs_bench;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [4:0]  clk_in = 5'h1F;
  logic [7:0]  reg_rdata;
  logic [4:0]  pad_out;
  logic [4:0]  oe_n;
  logic [15:0] mhz;
  logic [31:0] ps;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic [15:0] corner [4] = '{16'h05DC, 16'h0064, 16'h2EE0, 16'h1770};
  always #20 clk_sys = ~clk_sys;
  output_clock_control_regs i_dut (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .clk16m_in(clk_in[4]), .clk8m_in(clk_in[3]), .clk4m_in(clk_in[2]),
    .clk2m_in(clk_in[1]), .t1_clock_in(clk_in[0]), .clk_pad_out(pad_out),
    .clk_pad_oe_n(oe_n), .filter_sel_high(), .filter_sel_low(), .filter_corner(),
    .filter_corner_mhz(mhz), .t1_clock_phase_offset(), .t1_clock_phase_ps(ps));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, exp);
  endtask
  task automatic t_reset();
    rd(8'h13, 8'h00);
    rd(8'h12, 8'h00);
    chk("oe_n", oe_n, 5'h00);
    chk("mhz", mhz, 16'h05DC);
  endtask
  task automatic t_off();
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h13, 8'h02 << i);
      chk("oe_n", oe_n, 5'h01 << i);
      chk("pad_out", pad_out, 5'h1F & ~(5'h01 << i));
    end
    @(posedge clk_sys);
    clk_in <= 5'h15;
    @(posedge clk_sys);
    #1 chk("pad_out", pad_out, 5'h05);
    wr(8'h13, 8'hFF);
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h00);
    rd(8'h13, 8'h3E);
  endtask
  task automatic t_filter();
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h12, {2'b00, i[0], i[1], 4'h0});
      chk("mhz", mhz, corner[i]);
    end
  endtask
  task automatic t_phase();
    @(posedge clk_sys);
    clk_in <= 5'h00;
    // descending values prove the setting is absolute, not a relative shift
    for (int i = 7; i >= 0; i--)
    begin
      wr(8'h12, 8'hC8 | i[7:0]);
      chk("ps", ps, i * 80960);
      rd(8'h12, i[7:0]);
    end
  endtask
  task automatic t_rst();
    wr(8'h12, 8'h37);
    wr(8'h13, 8'h3E);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    #1 chk("oe_n", oe_n, 5'h00);
    chk("mhz", mhz, 16'h05DC);
    chk("ps", ps, 32'h00000000);
    rd(8'h13, 8'h00);
    rd(8'h12, 8'h00);
  endtask
  task automatic final_report();
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // run needs under a hundred cycles; ceiling leaves ample slack
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      final_report();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_off();
    t_filter();
    t_phase();
    t_rst();
    final_report();
  end
endmodule
